// file: core/ssr_pkg.sv
// constants, command codes and field layout of the supply control block
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package ssr_pkg;
  // decoded commands delivered by the command parser
  typedef enum logic [4:0] {
    C_NOP = 5'h00, C_VOLT_SET = 5'h01, C_CURR_SET = 5'h02, C_VOLT_CEIL = 5'h03,
    C_CURR_CEIL = 5'h04, C_OUT_ON = 5'h05, C_OUT_OFF = 5'h06, C_PROT_RST = 5'h07,
    C_TRIGGER = 5'h08, C_RECALL = 5'h09, C_SETTLE = 5'h0A, C_SREQ_ON = 5'h0B,
    C_SREQ_OFF = 5'h0C, C_FB_CURR = 5'h0D, C_FB_VOLT = 5'h0E, C_FB_NONE = 5'h0F,
    C_UNMASK = 5'h10, C_HOLD_ON = 5'h11, C_HOLD_OFF = 5'h12, C_ERR_Q = 5'h13,
    C_ALARM_Q = 5'h14, C_TRIP_Q = 5'h15, C_CLEAR = 5'h16
  } ssr_cmd_type;
  // foldback selection
  typedef enum logic [1:0] {FB_NONE = 2'h0, FB_CURR = 2'h1, FB_VOLT = 2'h2} ssr_fold_type;
  // status bit positions, shared by status, mask and alarm registers
  localparam int ST_W = 9;
  localparam int ST_ERR = 0, ST_OV = 1, ST_OVR = 2, ST_OT = 3, ST_AC = 4;
  localparam int ST_FOLD = 5, ST_CURR = 6, ST_VOLT = 7, ST_RSD = 8;
  // regulation bits hidden while settling: bits 7, 6 and 2
  localparam logic [8:0] HIDE_MASK = 9'h0C4;
  localparam logic [8:0] MASK_RST = 9'h000;
  // serial poll byte positions
  localparam int PB_SUM = 0, PB_PWR = 1, PB_RDY = 4, PB_ERR = 5, PB_RQS = 6;
  // error codes
  localparam logic [3:0] ERR_NONE = 4'h0, ERR_CHAR = 4'h1, ERR_NUM = 4'h2, ERR_ALPHA = 4'h3;
  localparam logic [3:0] ERR_SYNTAX = 4'h4, ERR_RANGE = 4'h5, ERR_SOFT = 4'h6;
  localparam logic [3:0] ERR_BADLIM = 4'h7, ERR_NOQUERY = 4'h8;
  // timing: one tick per millisecond at a 5 ns clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 1000000;
  localparam int CYC_PER_MS = TICK_NS / CLK_PERIOD_NS;
  // settling delay: 0.5 s default, 31.999 s maximum, in ms
  localparam int SETTLE_W = 15;
  localparam logic [14:0] SETTLE_DEF_MS = 15'h01F4;
  localparam int SETTLE_MAX_MS = 31999;
endpackage

// file: core/ssr_settle_timer.sv
// millisecond settling delay counter
`timescale 1ns/1ps
`default_nettype none
module ssr_settle_timer
  import ssr_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS // clock cycles per millisecond
) (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic start, // one-cycle pulse, (re)starts the delay
  input wire logic [SETTLE_W-1:0] limitMs, // delay length in ms
  output logic busy // high while the delay runs
);
  localparam int CW = $clog2(CYC_MS + 1);
  if (CYC_MS < 1) begin : g_chk
    $error("CYC_MS must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [CW-1:0] cyc_r; // cycles within the current ms
  logic [SETTLE_W-1:0] ms_r; // ms elapsed
  logic [SETTLE_W-1:0] lim_r; // limit caught at start, so a new value waits
  logic busy_r; // delay running
  wire logic tickEnd = (cyc_r == CW'(CYC_MS - 1));
  wire logic lastMs = (ms_r + 1'b1 == lim_r);

  // a start while running simply restarts from zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_r <= '0;
      ms_r <= '0;
      lim_r <= '0;
      busy_r <= 1'b0;
    end else if (start) begin
      cyc_r <= '0;
      ms_r <= '0;
      lim_r <= limitMs;
      busy_r <= (limitMs != '0); // zero delay hides nothing
    end else if (busy_r) begin
      cyc_r <= tickEnd ? '0 : cyc_r + 1'b1;
      if (tickEnd) begin
        ms_r <= ms_r + 1'b1;
        busy_r <= !lastMs;
      end
    end
  end
  assign busy = busy_r;

  a_idle_stays: assert property (@(posedge mclk) disable iff (!reset_n)
    !busy_r && !start |=> !busy_r) else $error("delay ran without a start");
endmodule
`default_nettype wire

// file: core/ssr_control.sv
// control, status and service request logic of the supply
`timescale 1ns/1ps
`default_nettype none
module ssr_control
  import ssr_pkg::*;
#(
  parameter int DW = 16, // setpoint and query data width
  parameter int CYC_MS = CYC_PER_MS // clock cycles per ms tick
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic reset_n, // async reset, power-on
  input wire logic cmdValid, // pulse: a parsed command is offered
  input wire ssr_cmd_type cmdCode, // decoded command
  input wire logic [DW-1:0] cmdData, // numeric argument
  input wire logic [3:0] parseErr, // parser error code, zero if clean
  input wire logic busTrigger, // pulse: group execute trigger
  input wire logic serialPoll, // pulse: serial poll taken
  input wire logic [ST_W-1:0] condIn, // analog-side conditions
  input wire logic [DW-1:0] measVolt, // present output voltage
  input wire logic [DW-1:0] measCurr, // present output current
  input wire logic [DW-1:0] tripLevel, // overvoltage trip level
  input wire logic remoteShutdown, // rear shutdown input, high active
  output logic outEnable, // output stage enable
  output logic srqOut, // service request to the bus
  output logic faultPin, // rear fault output
  output logic [7:0] pollByte, // serial poll status byte
  output logic [DW-1:0] queryData, // query answer
  output logic queryValid, // pulse: query answer valid
  output logic [DW-1:0] voltSet, // active voltage setpoint
  output logic [DW-1:0] currSet, // active current setpoint
  output logic settling // settling delay running
);
  if (DW < SETTLE_W) begin : g_chk
    $error("DW must hold the settling delay value");
  end

  // ---------------------------------------------------------------
  // layout of the dual-rank settings word
  // ---------------------------------------------------------------
  localparam int RK_CUR = DW; // current setpoint low bit
  localparam int RK_FB = 2 * DW; // foldback selection low bit
  localparam int RK_MK = 2 * DW + 2; // mask low bit
  localparam int RK_W = 2 * DW + 2 + ST_W; // total width

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [RK_W-1:0] rank1_r; // first rank, written by commands
  logic [RK_W-1:0] rank1Nxt; // first rank after this cycle
  logic [RK_W-1:0] rank2_r; // second, active rank
  logic hold_r; // hold mode on
  logic [DW-1:0] vCeil_r; // voltage ceiling
  logic [DW-1:0] iCeil_r; // current ceiling
  logic [SETTLE_W-1:0] settleMs_r; // programmed delay, ms
  logic srqEn_r; // service request enable
  logic rqs_r; // requesting service
  logic pwr_r; // power-up flag
  logic errFlag_r; // programming error flag
  logic [3:0] errCode_r; // last error code
  logic [ST_W-1:0] effPrev_r; // visible status, last cycle
  logic [ST_W-1:0] alarm_r; // alarm register
  logic sumPrev_r; // summary, last cycle
  logic foldTrip_r; // foldback tripped
  logic ovLatch_r; // overvoltage tripped
  logic outOn_r; // output programmed on
  logic outEnable_r; // output stage enable
  logic faultPin_r; // rear fault level
  logic rdy_r; // ready to process
  logic [7:0] pollByte_r; // poll byte
  logic [DW-1:0] queryData_r; // query answer
  logic queryValid_r; // query answer strobe
  logic settleBusy; // settling delay running

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic [3:0] errNew; // error code of this command
  logic cmdErr; // this command is refused
  logic exec; // this command executes

  // a command that executes this cycle
  function automatic logic run(input ssr_cmd_type c);
    return exec && (cmdCode == c);
  endfunction

  // ceiling checks compare against the stored limits
  wire logic voltOver = cmdValid && (cmdCode == C_VOLT_SET) && (cmdData > vCeil_r);
  wire logic currOver = cmdValid && (cmdCode == C_CURR_SET) && (cmdData > iCeil_r);
  // a ceiling below the present output cannot be set
  wire logic ceilBad = cmdValid && (((cmdCode == C_VOLT_CEIL) && (measVolt > cmdData))
                      || ((cmdCode == C_CURR_CEIL) && (measCurr > cmdData)));
  wire logic dlyBad = cmdValid && (cmdCode == C_SETTLE) && (cmdData > DW'(SETTLE_MAX_MS));

  // parser errors take priority, then limits, then range
  assign errNew = !cmdValid ? ERR_NONE
                : (parseErr != ERR_NONE) ? parseErr
                : (voltOver || currOver) ? ERR_SOFT
                : ceilBad ? ERR_BADLIM
                : dlyBad ? ERR_RANGE
                : ERR_NONE;
  assign cmdErr = (errNew != ERR_NONE);
  assign exec = cmdValid && !cmdErr;

  wire logic clr = run(C_CLEAR); // clear acts as a soft reset
  // trigger by command, its alias shares the code, or bus trigger
  wire logic trig = run(C_TRIGGER) || busTrigger;
  wire logic holdRel = run(C_HOLD_OFF);
  // setpoints only start settling when a trigger or the hold release copies them
  wire logic settleStart = run(C_OUT_ON) || run(C_PROT_RST) || trig
                        || run(C_RECALL) || holdRel;

  // ---------------------------------------------------------------
  // dual-rank settings
  // ---------------------------------------------------------------
  // first rank takes every accepted setpoint, foldback and mask write
  always_comb begin
    rank1Nxt = rank1_r;
    if (run(C_VOLT_SET)) begin
      rank1Nxt[DW-1:0] = cmdData;
    end
    if (run(C_CURR_SET)) begin
      rank1Nxt[RK_CUR +: DW] = cmdData;
    end
    if (run(C_FB_CURR)) begin
      rank1Nxt[RK_FB +: 2] = FB_CURR;
    end
    if (run(C_FB_VOLT)) begin
      rank1Nxt[RK_FB +: 2] = FB_VOLT;
    end
    if (run(C_FB_NONE)) begin
      rank1Nxt[RK_FB +: 2] = FB_NONE;
    end
    if (run(C_UNMASK)) begin
      rank1Nxt[RK_MK +: ST_W] = cmdData[ST_W-1:0];
    end
    if (clr) begin
      rank1Nxt = '0;
    end
  end

  // out of hold both ranks move together; in hold only a trigger,
  // the release or clear copies, so several supplies can switch at once
  wire logic rankCopy = !hold_r || trig || holdRel || clr;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rank1_r <= '0;
      rank2_r <= '0;
    end else begin
      rank1_r <= rank1Nxt;
      rank2_r <= rankCopy ? rank1Nxt : rank2_r;
    end
  end

  wire logic [ST_W-1:0] maskAct = rank2_r[RK_MK +: ST_W]; // active mask
  wire logic [1:0] fbAct = rank2_r[RK_FB +: 2]; // active foldback

  // hold mode, ceilings and delay setting; ceilings survive clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= 1'b0;
      vCeil_r <= '1;
      iCeil_r <= '1;
      settleMs_r <= SETTLE_DEF_MS;
      srqEn_r <= 1'b0;
    end else begin
      if (run(C_HOLD_ON)) begin
        hold_r <= 1'b1;
      end else if (holdRel || clr) begin
        hold_r <= 1'b0;
      end
      if (run(C_VOLT_CEIL)) begin
        vCeil_r <= cmdData;
      end
      if (run(C_CURR_CEIL)) begin
        iCeil_r <= cmdData;
      end
      if (clr) begin
        settleMs_r <= SETTLE_DEF_MS;
      end else if (run(C_SETTLE)) begin
        settleMs_r <= cmdData[SETTLE_W-1:0];
      end
      if (run(C_SREQ_ON)) begin
        srqEn_r <= 1'b1;
      end else if (run(C_SREQ_OFF) || clr) begin
        srqEn_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // settling delay
  // ---------------------------------------------------------------
  ssr_settle_timer #(
    .CYC_MS(CYC_MS)
  ) u_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(settleStart),
    .limitMs(settleMs_r),
    .busy(settleBusy)
  );

  // ---------------------------------------------------------------
  // status and alarm register
  // ---------------------------------------------------------------
  logic [ST_W-1:0] present; // present status
  always_comb begin
    present = condIn;
    present[ST_ERR] = errFlag_r;
    present[ST_FOLD] = foldTrip_r;
    present[ST_RSD] = remoteShutdown;
  end

  // regulation bits vanish while settling, for alarms and foldback
  wire logic [ST_W-1:0] hide = settleBusy ? HIDE_MASK : '0;
  wire logic [ST_W-1:0] eff = present & ~hide;
  wire logic [ST_W-1:0] alarmSet = eff & ~effPrev_r & maskAct;
  wire logic alarmRead = run(C_ALARM_Q);
  wire logic summary = |alarm_r;
  // a masked error reaches the request through the alarm path
  wire logic rqsSet = summary && !sumPrev_r && srqEn_r;

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      effPrev_r <= '0;
      alarm_r <= '0;
      sumPrev_r <= 1'b0;
      rqs_r <= 1'b0;
    end else begin
      effPrev_r <= eff;
      alarm_r <= alarmSet | ((alarmRead || clr) ? '0 : alarm_r);
      sumPrev_r <= summary;
      rqs_r <= rqsSet || (rqs_r && !(serialPoll || clr));
    end
  end

  // ---------------------------------------------------------------
  // programming error register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      errFlag_r <= 1'b0;
      errCode_r <= ERR_NONE;
      pwr_r <= 1'b1;
    end else begin
      errFlag_r <= cmdErr || (errFlag_r && !(run(C_ERR_Q) || clr));
      if (cmdErr) begin
        errCode_r <= errNew;
      end else if (run(C_ERR_Q) || clr) begin
        errCode_r <= ERR_NONE;
      end
      pwr_r <= pwr_r && !clr; // only clear drops the power-up flag
    end
  end

  // ---------------------------------------------------------------
  // protection and output enable
  // ---------------------------------------------------------------
  // foldback looks at the settled status only
  wire logic foldHit = ((fbAct == FB_CURR) && eff[ST_CURR])
                    || ((fbAct == FB_VOLT) && eff[ST_VOLT]);
  wire logic protClr = run(C_PROT_RST) || clr;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      foldTrip_r <= 1'b0;
      ovLatch_r <= 1'b0;
      outOn_r <= 1'b1;
    end else begin
      foldTrip_r <= (foldHit && outOn_r) || (foldTrip_r && !(protClr || run(C_OUT_ON)));
      ovLatch_r <= condIn[ST_OV] || (ovLatch_r && !protClr);
      if (run(C_OUT_ON) || clr) begin
        outOn_r <= 1'b1;
      end else if (run(C_OUT_OFF)) begin
        outOn_r <= 1'b0;
      end
    end
  end

  // shutdown input bypasses every bus setting
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      outEnable_r <= 1'b0;
    end else begin
      outEnable_r <= outOn_r && !foldTrip_r && !ovLatch_r && !remoteShutdown;
    end
  end

  // ---------------------------------------------------------------
  // fault pin, poll byte and query answers
  // ---------------------------------------------------------------
  logic [7:0] pbNxt; // poll byte contents
  always_comb begin
    pbNxt = 8'h00;
    pbNxt[PB_SUM] = summary;
    pbNxt[PB_PWR] = pwr_r;
    pbNxt[PB_RDY] = rdy_r;
    pbNxt[PB_ERR] = errFlag_r;
    pbNxt[PB_RQS] = rqs_r;
  end

  logic [DW-1:0] qNxt; // answer for this command
  always_comb begin
    qNxt = '0;
    if (run(C_ERR_Q)) begin
      qNxt = {{(DW - 4){1'b0}}, errCode_r};
    end else if (run(C_ALARM_Q)) begin
      qNxt = {{(DW - ST_W){1'b0}}, alarm_r};
    end else if (run(C_TRIP_Q)) begin
      qNxt = tripLevel;
    end
  end
  wire logic isQuery = run(C_ERR_Q) || run(C_ALARM_Q) || run(C_TRIP_Q);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      faultPin_r <= 1'b0;
      rdy_r <= 1'b1;
      pollByte_r <= 8'h00;
      queryData_r <= '0;
      queryValid_r <= 1'b0;
    end else begin
      faultPin_r <= |(alarm_r & maskAct);
      rdy_r <= !cmdValid; // busy for the cycle a command is taken
      pollByte_r <= pbNxt;
      queryData_r <= isQuery ? qNxt : queryData_r;
      queryValid_r <= isQuery;
    end
  end

  assign outEnable = outEnable_r;
  assign srqOut = rqs_r;
  assign faultPin = faultPin_r;
  assign pollByte = pollByte_r;
  assign queryData = queryData_r;
  assign queryValid = queryValid_r;
  assign voltSet = rank2_r[DW-1:0];
  assign currSet = rank2_r[RK_CUR +: DW];
  assign settling = settleBusy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_badCmd;
    cmdValid && cmdErr;
  endsequence
  sequence s_foldEntry;
    (fbAct == FB_CURR) && eff[ST_CURR] && outOn_r && !settleBusy;
  endsequence

  a_srq_raise: assert property (summary && !sumPrev_r && srqEn_r |=> rqs_r)
    else $error("request not raised on summary rise");
  a_srq_gate: assert property (!srqEn_r && !rqs_r |=> !rqs_r)
    else $error("request raised while disabled");
  a_settle_hide: assert property (settleBusy && !alarm_r[ST_CURR] ##1 settleBusy |-> !alarm_r[ST_CURR])
    else $error("regulation bit reached alarms while settling");
  a_fold_hide: assert property (settleBusy && !foldTrip_r && !eff[ST_OV] |=> !foldTrip_r)
    else $error("foldback tripped while settling");
  a_err_noexec: assert property (s_badCmd |=> $stable(rank1_r) && $stable(vCeil_r))
    else $error("refused command changed settings");
  a_err_flag: assert property (s_badCmd |=> errFlag_r ##1 pollByte_r[PB_ERR])
    else $error("error not flagged in poll byte");
  a_ceil_over: assert property (cmdValid && parseErr == ERR_NONE && cmdCode == C_VOLT_SET
    && cmdData > vCeil_r |=> errCode_r == ERR_SOFT)
    else $error("setpoint above ceiling not refused");
  a_fold_trip: assert property (s_foldEntry |=> foldTrip_r ##1 !outEnable_r)
    else $error("current foldback did not disable output");
  a_shutdown_off: assert property (remoteShutdown |=> !outEnable_r)
    else $error("output on during remote shutdown");
  a_hold_rank: assert property (hold_r && !trig && !holdRel && !clr |=> $stable(rank2_r))
    else $error("active rank changed in hold without trigger");
  a_poll_clear: assert property (serialPoll && !rqsSet |=> !rqs_r)
    else $error("serial poll left request set");
endmodule
`default_nettype wire

// file: sim/ssr_bus_ctrl.sv
// bus controller model: parsed commands, triggers and polls
`timescale 1ns/1ps
`default_nettype none
module ssr_bus_ctrl
  import ssr_pkg::*;
(
  input wire logic mclk, // system clock
  output logic cmdValid, // command strobe
  output var ssr_cmd_type cmdCode, // decoded command
  output logic [15:0] cmdData, // argument
  output logic [3:0] parseErr, // parser error code
  output logic busTrigger, // group trigger pulse
  output logic serialPoll // poll pulse
);
  // idle bus at time zero
  initial begin
    cmdValid = 1'h0;
    cmdCode = C_NOP;
    cmdData = 16'h0000;
    parseErr = 4'h0;
    busTrigger = 1'h0;
    serialPoll = 1'h0;
  end
  // one command per strobe; stale data is inverted so it cannot pass
  task automatic send(input ssr_cmd_type c, input logic [15:0] d, input logic [3:0] e);
    @(posedge mclk);
    cmdValid <= 1'h1;
    cmdCode <= c;
    cmdData <= d;
    parseErr <= e;
    @(posedge mclk);
    cmdValid <= 1'h0;
    cmdData <= ~d;
    parseErr <= 4'h0;
  endtask
  // one-cycle trigger or poll message
  task automatic pulse(input logic poll);
    @(posedge mclk);
    busTrigger <= ~poll;
    serialPoll <= poll;
    @(posedge mclk);
    busTrigger <= 1'h0;
    serialPoll <= 1'h0;
  endtask
endmodule
`default_nettype wire

// file: sim/supply_status_request_control_tb.sv
// self-checking bench of the supply control block
`timescale 1ns/1ps
`default_nettype none
module supply_status_request_control_tb;
  import ssr_pkg::*;
  logic mclk, reset_n, cmdValid, busTrigger, serialPoll, remoteShutdown; // stimulus
  ssr_cmd_type cmdCode; // command from the model
  logic [15:0] cmdData, measVolt, measCurr, tripLevel, queryData, voltSet, currSet; // data paths
  logic [3:0] parseErr; // parser code
  logic [8:0] condIn; // analog conditions
  logic outEnable, srqOut, faultPin, queryValid, settling; // flags
  logic [7:0] pollByte; // poll status
  int err_total, checks, seed, mv, ceil, d; // counters and reference model
  // short tick keeps the half-second delay at 2000 cycles
  ssr_control #(.DW(16), .CYC_MS(4)) uut (.mclk, .reset_n, .cmdValid, .cmdCode, .cmdData,
    .parseErr, .busTrigger, .serialPoll, .condIn, .measVolt, .measCurr, .tripLevel,
    .remoteShutdown, .outEnable, .srqOut, .faultPin, .pollByte, .queryData, .queryValid,
    .voltSet, .currSet, .settling);
  ssr_bus_ctrl bc (.mclk, .cmdValid, .cmdCode, .cmdData, .parseErr, .busTrigger, .serialPoll);
  // 200 MHz clock
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // settle past the edge before sampling
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // the answer stands for the one cycle that follows the taking edge
  task automatic qry(input ssr_cmd_type c, input logic [15:0] e);
    bc.send(c, 16'h0000, 4'h0);
    #1;
    chk({15'h0, queryValid}, 16'h0001);
    chk(queryData, e);
  endtask
  // refused command: nothing runs, flag raised, code read back, flag cleared
  task automatic bad(input ssr_cmd_type c, input logic [15:0] dd, input logic [3:0] pe, input logic [3:0] code);
    bc.send(c, dd, pe);
    w(2);
    chk({15'h0, pollByte[PB_ERR]}, 16'h0001);
    chk(voltSet, mv[15:0]);
    qry(C_ERR_Q, {12'h000, code});
    w(1);
    chk({15'h0, pollByte[PB_ERR]}, 16'h0000);
  endtask
  // closing verdict
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    seed = 32'h2897AE7D;
    err_total = 0;
    checks = 0;
    mv = 0;
    d = $random(seed);
    reset_n = 1'h0;
    condIn = 9'h000;
    measVolt = 16'h0100;
    measCurr = 16'h0010;
    tripLevel = d[15:0];
    remoteShutdown = 1'h0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'h1;
    w(2);
    chk({8'h00, pollByte}, 16'h0012);
    bad(C_VOLT_SET, 16'h0050, 4'h2, ERR_NUM);
    bad(C_VOLT_CEIL, 16'h0080, 4'h0, ERR_BADLIM);
    d = $random(seed);
    ceil = 16'h0200 + d[7:0];
    bc.send(C_VOLT_CEIL, ceil[15:0], 4'h0);
    bad(C_VOLT_SET, ceil[15:0] + 16'h0001, 4'h0, ERR_SOFT);
    bad(C_SETTLE, 16'h7D00, 4'h0, ERR_RANGE);
    mv = ceil - 1;
    bc.send(C_VOLT_SET, mv[15:0], 4'h0);
    w(1);
    chk(voltSet, mv[15:0]);
    qry(C_TRIP_Q, tripLevel);
    // request path: unmasked current regulation
    bc.send(C_UNMASK, 16'h0040, 4'h0);
    bc.send(C_SREQ_ON, 16'h0000, 4'h0);
    @(posedge mclk) condIn <= 9'h040;
    w(4);
    chk({13'h0, pollByte[PB_RQS], srqOut, faultPin}, 16'h0007);
    qry(C_ALARM_Q, 16'h0040);
    bc.pulse(1'h1);
    w(3);
    chk({13'h0, pollByte[PB_RQS], srqOut, faultPin}, 16'h0000);
    bc.send(C_SREQ_OFF, 16'h0000, 4'h0);
    @(posedge mclk) condIn <= 9'h000;
    @(posedge mclk) condIn <= 9'h040;
    w(4);
    chk({14'h0, srqOut, faultPin}, 16'h0001);
    qry(C_ALARM_Q, 16'h0040);
    // current foldback trips, output on restarts settling
    bc.send(C_FB_CURR, 16'h0000, 4'h0);
    w(3);
    chk({15'h0, outEnable}, 16'h0000);
    @(posedge mclk) condIn <= 9'h000;
    bc.send(C_FB_NONE, 16'h0000, 4'h0);
    bc.send(C_OUT_ON, 16'h0000, 4'h0);
    w(1);
    chk({15'h0, settling}, 16'h0001);
    bc.send(C_FB_CURR, 16'h0000, 4'h0);
    @(posedge mclk) condIn <= 9'h040;
    w(5);
    chk({14'h0, outEnable, faultPin}, 16'h0002);
    @(posedge mclk) condIn <= 9'h000;
    bc.send(C_FB_NONE, 16'h0000, 4'h0);
    w(1970);
    chk({15'h0, settling}, 16'h0001);
    w(30);
    chk({15'h0, settling}, 16'h0000);
    // voltage foldback, then overvoltage latch
    bc.send(C_FB_VOLT, 16'h0000, 4'h0);
    @(posedge mclk) condIn <= 9'h080;
    w(3);
    chk({15'h0, outEnable}, 16'h0000);
    @(posedge mclk) condIn <= 9'h002;
    bc.send(C_FB_NONE, 16'h0000, 4'h0);
    bc.send(C_OUT_ON, 16'h0000, 4'h0);
    @(posedge mclk) condIn <= 9'h000;
    w(3);
    chk({15'h0, outEnable}, 16'h0000);
    bc.send(C_PROT_RST, 16'h0000, 4'h0);
    w(3);
    chk({15'h0, outEnable}, 16'h0001);
    // hold mode with both trigger forms
    bc.send(C_HOLD_ON, 16'h0000, 4'h0);
    for (int k = 0; k < 2; k++) begin
      d = $random(seed);
      bc.send(C_VOLT_SET, {8'h00, d[7:0]}, 4'h0);
      w(2);
      chk(voltSet, mv[15:0]);
      mv = d[7:0];
      if (k == 0)
        bc.pulse(1'h0);
      else
        bc.send(C_TRIGGER, 16'h0000, 4'h0);
      w(2);
      chk(voltSet, mv[15:0]);
    end
    bc.send(C_HOLD_OFF, 16'h0000, 4'h0);
    bc.send(C_CURR_SET, {8'h00, d[15:8]}, 4'h0);
    w(1);
    chk(currSet, {8'h00, d[15:8]});
    @(posedge mclk) remoteShutdown <= 1'h1;
    w(3);
    chk({15'h0, outEnable}, 16'h0000);
    @(posedge mclk) remoteShutdown <= 1'h0;
    w(3);
    chk({15'h0, outEnable}, 16'h0001);
    // masked programming error raises a request through the alarm path
    bc.send(C_UNMASK, 16'h0001, 4'h0);
    bc.send(C_SREQ_ON, 16'h0000, 4'h0);
    bad(C_CURR_SET, 16'h0001, 4'h4, ERR_SYNTAX);
    chk({15'h0, srqOut}, 16'h0001);
    // clear drops power-up flag, request and active setpoints
    bc.send(C_CLEAR, 16'h0000, 4'h0);
    w(2);
    chk({8'h00, pollByte}, 16'h0010);
    chk(voltSet, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
